// ===== fruj_pkg.sv
// Package with operation codes, field layouts and carrier structs for the unary/jump unit.
package fruj_pkg;

  // Field widths of the decoded operands.
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned FADDR_W  = 7;
  localparam int unsigned LIT_W    = 11;
  localparam int unsigned PC_W     = 13;
  localparam int unsigned PAGE_W   = 2;

  // Page-latch field position that feeds the upper program counter bits.
  localparam int unsigned PAGE_LO  = 3;
  localparam int unsigned PAGE_HI  = 4;

  // Destination select values.
  localparam logic DEST_WORK = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // Constant byte values.
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE  = 8'h01;
  localparam logic [7:0] BYTE_MAX  = 8'hff;

  // Operations this unit executes.
  typedef enum logic [2:0] {
    FRUJ_OP_NONE,
    FRUJ_OP_COMPLEMENT_FILE,
    FRUJ_OP_CLEAR_WORKING,
    FRUJ_OP_DECREMENT_FILE,
    FRUJ_OP_DECREMENT_SKIP_ZERO,
    FRUJ_OP_INCREMENT_SKIP_ZERO,
    FRUJ_OP_UNCONDITIONAL_JUMP
  } fruj_op_type;

  // Decoded instruction from the decoder.
  typedef struct packed {
    fruj_op_type        op;
    logic               dest;
    logic [6:0]         faddr;
    logic [10:0]        literal;
  } fruj_instr_type;

  // Write-back results toward register file, status and program counter.
  typedef struct packed {
    logic               work_we;
    logic               file_we;
    logic [6:0]         faddr;
    logic [7:0]         data;
    logic               zero_we;
    logic               zero_val;
    logic               pc_we;
    logic [12:0]        pc_val;
    logic               flush;
  } fruj_result_type;

endpackage

// ===== fruj_alu.sv
// Combinational byte unit: complement, decrement, increment and zero detect.
`timescale 1ns/100ps
module fruj_alu #(
  parameter int unsigned WIDTH = fruj_pkg::DATA_W
) (
  // Operation and operand.
  input  wire fruj_pkg::fruj_op_type op,
  input  wire logic [WIDTH-1:0]      operand,
  // Result.
  output logic [WIDTH-1:0]           result,
  output logic                       is_zero
);

  initial begin
    if (WIDTH != fruj_pkg::DATA_W) begin
      $error("fruj_alu supports only the 8-bit data width");
    end
  end

  wire logic [WIDTH-1:0] one_w = WIDTH'(fruj_pkg::BYTE_ONE);
  // The width of each sum equals the operand, so wraparound is modulo 256.
  wire logic [WIDTH-1:0] inc_w = operand + one_w;
  wire logic [WIDTH-1:0] dec_w = operand - one_w;
  wire logic [WIDTH-1:0] cpl_w = ~operand;

  // Result selection by operation.
  assign result =
    (op == fruj_pkg::FRUJ_OP_COMPLEMENT_FILE)     ? cpl_w :
    (op == fruj_pkg::FRUJ_OP_DECREMENT_FILE)      ? dec_w :
    (op == fruj_pkg::FRUJ_OP_DECREMENT_SKIP_ZERO) ? dec_w :
    (op == fruj_pkg::FRUJ_OP_INCREMENT_SKIP_ZERO) ? inc_w :
    WIDTH'(fruj_pkg::BYTE_ZERO);
  assign is_zero = (result == WIDTH'(fruj_pkg::BYTE_ZERO));

endmodule

// ===== fruj_unit.sv
// Execution unit for file complement, clear working, decrements, increment-skip and jump.
`timescale 1ns/100ps
module fruj_unit (
  // Clock and reset.
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  // Decoded instruction, valid for one cycle.
  input  wire logic                         instr_valid,
  input  wire fruj_pkg::fruj_instr_type     instr,
  // Operand read from the addressed file register.
  input  wire logic [7:0]                   file_rdata,
  // Page latch register contents.
  input  wire logic [7:0]                   page_latch_upper,
  // Registered write-back results.
  output fruj_pkg::fruj_result_type         result,
  // High while the unit accepts a new instruction.
  output logic                              ready
);

  // Pipeline state: the second cycle of a skip or jump executes a no-operation.
  typedef enum logic {
    FRUJ_ST_RUN,
    FRUJ_ST_FLUSH
  } fruj_state_type;

  fruj_state_type            state_q;
  fruj_state_type            state_d;
  fruj_pkg::fruj_result_type result_q;
  fruj_pkg::fruj_result_type result_d;

  wire logic [7:0] alu_res;
  wire logic       alu_zero;

  // Shared byte arithmetic.
  fruj_alu #(
    .WIDTH (fruj_pkg::DATA_W)
  ) u_alu (
    .op      (instr.op),
    .operand (file_rdata),
    .result  (alu_res),
    .is_zero (alu_zero)
  );

  // Operation decode; a flushed slot takes nothing, acting as a no-operation.
  wire logic take    = instr_valid && (state_q == FRUJ_ST_RUN);
  wire logic is_cpl  = take && (instr.op == fruj_pkg::FRUJ_OP_COMPLEMENT_FILE);
  wire logic is_clear_working_op = take && (instr.op == fruj_pkg::FRUJ_OP_CLEAR_WORKING);
  wire logic is_dec  = take && (instr.op == fruj_pkg::FRUJ_OP_DECREMENT_FILE);
  wire logic is_dsz  = take && (instr.op == fruj_pkg::FRUJ_OP_DECREMENT_SKIP_ZERO);
  wire logic is_isz  = take && (instr.op == fruj_pkg::FRUJ_OP_INCREMENT_SKIP_ZERO);
  wire logic is_jmp  = take && (instr.op == fruj_pkg::FRUJ_OP_UNCONDITIONAL_JUMP);
  wire logic is_byte = is_cpl || is_dec || is_dsz || is_isz;
  wire logic to_file = (instr.dest == fruj_pkg::DEST_FILE);

  // Skip fires on a zero result; the jump always flushes.
  wire logic skip_w  = (is_dsz || is_isz) && alu_zero;
  wire logic flush_w = skip_w || is_jmp;

  // Jump target: page bits above the 11-bit literal.
  wire logic [1:0]  page_w = page_latch_upper[fruj_pkg::PAGE_HI:fruj_pkg::PAGE_LO];
  wire logic [12:0] target_w = {page_w, instr.literal};

  // Next write-back values.
  always_comb begin
    result_d          = '0;
    result_d.faddr    = instr.faddr;
    result_d.work_we  = (is_byte && !to_file) || is_clear_working_op;
    result_d.file_we  = is_byte && to_file;
    result_d.data     = is_clear_working_op ? fruj_pkg::BYTE_ZERO : alu_res;
    // Only complement, decrement and clear touch the zero flag.
    result_d.zero_we  = is_cpl || is_dec || is_clear_working_op;
    result_d.zero_val = is_clear_working_op ? 1'b1 : alu_zero;
    result_d.pc_we    = is_jmp;
    result_d.pc_val   = is_jmp ? target_w : '0;
    result_d.flush    = flush_w;
  end

  // Enter the no-operation slot after a taken skip or a jump.
  assign state_d = flush_w ? FRUJ_ST_FLUSH : FRUJ_ST_RUN;

  // State and result registers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= FRUJ_ST_RUN;
      result_q <= '0;
    end else begin
      state_q  <= state_d;
      result_q <= result_d;
    end
  end

  assign result = result_q;
  // During the flush slot the fetched instruction is discarded.
  assign ready  = (state_q == FRUJ_ST_RUN);

  // Checks.
  property p_cpl;
    @(posedge sys_clk) disable iff (!rst_n)
      is_cpl |=> result.zero_we && (result.data == ~$past(file_rdata))
                 && (result.file_we == $past(to_file)) && (result.work_we != result.file_we);
  endproperty
  a_cpl: assert property (p_cpl) else $error("complement result wrong");

  property p_clear_working_op;
    @(posedge sys_clk) disable iff (!rst_n)
      is_clear_working_op |=> result.work_we && result.zero_we && result.zero_val
                  && (result.data == fruj_pkg::BYTE_ZERO);
  endproperty
  a_clear_working_op: assert property (p_clear_working_op) else $error("clear working wrong");

  property p_dec;
    @(posedge sys_clk) disable iff (!rst_n)
      is_dec |=> result.zero_we && (result.data == $past(file_rdata) - 8'h01)
                 && (result.zero_val == (result.data == 8'h00));
  endproperty
  a_dec: assert property (p_dec) else $error("decrement wrong");

  property p_dsz_data;
    @(posedge sys_clk) disable iff (!rst_n)
      is_dsz |=> !result.zero_we && (result.data == $past(file_rdata) - 8'h01)
                 && (result.file_we == $past(to_file));
  endproperty
  a_dsz_data: assert property (p_dsz_data) else $error("decrement-skip data wrong");

  property p_dsz_skip;
    @(posedge sys_clk) disable iff (!rst_n)
      (is_dsz && file_rdata == 8'h01) |=> result.flush && !ready ##1 ready;
  endproperty
  a_dsz_skip: assert property (p_dsz_skip) else $error("decrement-skip flush wrong");

  property p_isz_data;
    @(posedge sys_clk) disable iff (!rst_n)
      is_isz |=> !result.zero_we && (result.data == $past(file_rdata) + 8'h01);
  endproperty
  a_isz_data: assert property (p_isz_data) else $error("increment-skip data wrong");

  property p_isz_skip;
    @(posedge sys_clk) disable iff (!rst_n)
      is_isz |=> (result.flush == ($past(file_rdata) == 8'hff)) && (ready == !result.flush);
  endproperty
  a_isz_skip: assert property (p_isz_skip) else $error("increment-skip flush wrong");

  property p_jmp;
    @(posedge sys_clk) disable iff (!rst_n)
      is_jmp |=> result.pc_we && !result.zero_we && result.flush
                 && (result.pc_val == {$past(page_latch_upper[4:3]), $past(instr.literal)});
  endproperty
  a_jmp: assert property (p_jmp) else $error("jump target wrong");

  property p_jmp_two;
    @(posedge sys_clk) disable iff (!rst_n)
      is_jmp |=> !ready ##1 (ready && !result.pc_we && !result.work_we && !result.file_we);
  endproperty
  a_jmp_two: assert property (p_jmp_two) else $error("jump not two cycles");

  // The slot after a skip or jump must leave no write, flag or flush behind.
  property p_refuse;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_q == FRUJ_ST_FLUSH) |=> !result.work_we && !result.file_we && !result.pc_we
                                     && !result.zero_we && !result.flush;
  endproperty
  a_refuse: assert property (p_refuse) else $error("flush slot not idle");

  // The complement must report zero exactly when its byte is zero.
  property p_cpl_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      is_cpl |=> (result.zero_val == (result.data == fruj_pkg::BYTE_ZERO));
  endproperty
  a_cpl_zero: assert property (p_cpl_zero) else $error("complement zero wrong");

  // Increment-skip routes its byte by the destination bit only.
  property p_isz_dest;
    @(posedge sys_clk) disable iff (!rst_n)
      is_isz |=> (result.file_we == $past(to_file)) && (result.work_we == !$past(to_file));
  endproperty
  a_isz_dest: assert property (p_isz_dest) else $error("increment-skip route wrong");

  // Decrement-skip routes its byte by the destination bit only.
  property p_dsz_dest;
    @(posedge sys_clk) disable iff (!rst_n)
      is_dsz |=> (result.file_we == $past(to_file)) && (result.work_we == !$past(to_file));
  endproperty
  a_dsz_dest: assert property (p_dsz_dest) else $error("decrement-skip route wrong");

  // A nonzero decrement-skip result must not cost a cycle.
  property p_dsz_noskip;
    @(posedge sys_clk) disable iff (!rst_n)
      (is_dsz && !alu_zero) |=> !result.flush && ready;
  endproperty
  a_dsz_noskip: assert property (p_dsz_noskip) else $error("decrement-skip flushed");

  // Decrementing the zero byte wraps to the all-ones byte.
  property p_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
      (is_dec && file_rdata == fruj_pkg::BYTE_ZERO) |=> (result.data == fruj_pkg::BYTE_MAX)
                                                       && !result.zero_val;
  endproperty
  a_wrap: assert property (p_wrap) else $error("decrement wrap wrong");

  // The low program counter bits carry the whole eleven-bit literal.
  property p_jmp_lit;
    @(posedge sys_clk) disable iff (!rst_n)
      is_jmp |=> (result.pc_val[10:0] == $past(instr.literal));
  endproperty
  a_jmp_lit: assert property (p_jmp_lit) else $error("jump literal wrong");

  // An idle operation code writes nothing, so an undecoded slot is harmless.
  property p_none;
    @(posedge sys_clk) disable iff (!rst_n)
      (take && instr.op == fruj_pkg::FRUJ_OP_NONE) |=> !result.work_we && !result.file_we
                                                       && !result.pc_we && !result.zero_we;
  endproperty
  a_none: assert property (p_none) else $error("idle operation wrote");

  // Coverage of the main scenarios.
  c_dsz_skip: cover property (@(posedge sys_clk) disable iff (!rst_n) is_dsz && alu_zero);
  c_isz_wrap: cover property (@(posedge sys_clk) disable iff (!rst_n)
                              is_isz && file_rdata == 8'hff);
  c_jmp:      cover property (@(posedge sys_clk) disable iff (!rst_n) is_jmp);
  c_cpl_file: cover property (@(posedge sys_clk) disable iff (!rst_n) is_cpl && to_file);

endmodule

// ===== fruj_regfile_model.sv
// Behavioural register file that feeds operands to the unit and takes its write-back.
`timescale 1ns/100ps
module fruj_regfile_model (
  // Clock.
  input  wire logic                      sys_clk,
  // Preload port used by the bench.
  input  wire logic                      pre_we,
  input  wire logic [6:0]                pre_addr,
  input  wire logic [7:0]                pre_data,
  // Unit side.
  input  wire logic [6:0]                faddr,
  input  wire fruj_pkg::fruj_result_type result,
  output logic [7:0]                     file_rdata
);
  logic [7:0] mem_q [128];

  // Read is combinational, because the operand must arrive in the instruction cycle.
  assign file_rdata = mem_q[faddr];

  // Write-back lands one edge after the unit reports it; a preload wins a clash.
  always_ff @(posedge sys_clk) begin
    if (pre_we) begin
      mem_q[pre_addr] <= pre_data;
    end else if (result.file_we) begin
      mem_q[result.faddr] <= result.data;
    end
  end
endmodule

// ===== fruj_unit_tb_top.sv
// Self-checking bench for the unary and jump execution unit.
`timescale 1ns/100ps
module fruj_unit_tb_top;
  localparam fruj_pkg::fruj_op_type CMP = fruj_pkg::FRUJ_OP_COMPLEMENT_FILE;
  localparam fruj_pkg::fruj_op_type CLR = fruj_pkg::FRUJ_OP_CLEAR_WORKING;
  localparam fruj_pkg::fruj_op_type DEC = fruj_pkg::FRUJ_OP_DECREMENT_FILE;
  localparam fruj_pkg::fruj_op_type DSZ = fruj_pkg::FRUJ_OP_DECREMENT_SKIP_ZERO;
  localparam fruj_pkg::fruj_op_type ISZ = fruj_pkg::FRUJ_OP_INCREMENT_SKIP_ZERO;
  localparam fruj_pkg::fruj_op_type JMP = fruj_pkg::FRUJ_OP_UNCONDITIONAL_JUMP;
  logic                      sys_clk;
  logic                      rst_n;
  logic                      instr_valid;
  logic                      pre_we;
  logic                      ready;
  logic [6:0]                pre_addr;
  logic [7:0]                pre_data;
  logic [7:0]                file_rdata;
  logic [7:0]                page_latch_upper;
  fruj_pkg::fruj_instr_type  instr;
  fruj_pkg::fruj_result_type result;
  fruj_pkg::fruj_result_type exp_q[$];
  fruj_pkg::fruj_op_type     ops[11] = '{CMP, CMP, CLR, DEC, DEC, DSZ, DSZ, ISZ, ISZ, JMP,
                                         fruj_pkg::FRUJ_OP_NONE};
  logic [7:0]                vals[11] = '{8'hff, 8'h5a, 8'h33, 8'h01, 8'h00, 8'h01, 8'h05,
                                          8'hff, 8'h10, 8'h00, 8'h00};
  int                        failures;
  int                        samples_checked;

  fruj_unit i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .file_rdata(file_rdata), .page_latch_upper(page_latch_upper), .result(result),
    .ready(ready));
  fruj_regfile_model i_model (.sys_clk(sys_clk), .pre_we(pre_we), .pre_addr(pre_addr),
    .pre_data(pre_data), .faddr(instr.faddr), .result(result), .file_rdata(file_rdata));

  // Free-running 100 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Fields without meaning when their enable is low are cleared, so only real content counts.
  function automatic fruj_pkg::fruj_result_type mask(input fruj_pkg::fruj_result_type r);
    if (!r.file_we) r.faddr = 7'h00;
    if (!(r.file_we || r.work_we)) r.data = 8'h00;
    if (!r.zero_we) r.zero_val = 1'b0;
    if (!r.pc_we) r.pc_val = 13'h0000;
    return r;
  endfunction

  // Preloads the operand, issues one instruction, notes the result and probes the flush slot.
  task automatic issue(input fruj_pkg::fruj_op_type op, input logic dest, input logic [7:0] v);
    fruj_pkg::fruj_result_type e;
    logic [7:0]                r;
    logic                      dop;
    instr = '{op: op, dest: dest, faddr: 7'($urandom), literal: 11'($urandom)};
    page_latch_upper = 8'($urandom);
    pre_we = 1'b1;
    pre_addr = instr.faddr;
    pre_data = v;
    @(negedge sys_clk);
    pre_we = 1'b0;
    instr_valid = 1'b1;
    case (op)
      CMP: r = ~v;
      ISZ: r = v + 8'h01;
      CLR: r = 8'h00;
      default: r = v - 8'h01;
    endcase
    dop = op inside {CMP, DEC, DSZ, ISZ};
    e = '0;
    e.data = r;
    e.faddr = instr.faddr;
    e.work_we = (op == CLR) || (dop && !dest);
    e.file_we = dop && dest;
    e.zero_we = op inside {CMP, CLR, DEC};
    e.zero_val = (r == 8'h00);
    e.pc_we = (op == JMP);
    e.pc_val = {page_latch_upper[4:3], instr.literal};
    e.flush = (op == JMP) || (op inside {DSZ, ISZ} && r == 8'h00);
    if (op != fruj_pkg::FRUJ_OP_NONE) exp_q.push_back(e);
    @(negedge sys_clk);
    check("ready", 34'(ready), 34'(!e.flush));
    // A refused instruction in the flush slot must leave no trace at the outputs.
    if (e.flush) begin
      instr.op = CLR;
      @(negedge sys_clk);
    end
    instr_valid = 1'b0;
  endtask

  // Every non-idle result pops the oldest note; a result with no note is itself a mismatch.
  // The address field follows the decoder even when idle, so idleness is judged after masking.
  always @(negedge sys_clk) begin
    if (rst_n && mask(result) !== '0) begin
      if (exp_q.size() == 0) begin
        check("unexpected result", mask(result), '0);
      end else begin
        check("result", mask(result), mask(exp_q.pop_front()));
      end
    end
  end

  // Main sequence: boundary table for both destinations, then a reset, then random traffic.
  initial begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr = '0;
    pre_we = 1'b0;
    pre_addr = 7'h00;
    pre_data = 8'h00;
    page_latch_upper = 8'h00;
    void'($urandom(31));
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    for (int d = 0; d < 2; d++) begin
      for (int i = 0; i < 11; i++) issue(ops[i], 1'(d), vals[i]);
    end
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (60) issue(fruj_pkg::fruj_op_type'(3'($urandom_range(6))), 1'($urandom),
                      8'($urandom));
    for (int t = 0; t < 20 && exp_q.size() > 0; t++) @(negedge sys_clk);
    if (exp_q.size() > 0) failures++;
    end_of_test();
  end
endmodule
